// File: prot_ctrl_map.vh
// Purpose: register offsets, fields, reset values and timing counts
// Assumes: APB, 32-bit data, 250 MHz pclk
// Notes: times in ns, blank, loop-loss and discharge counts derived from the clock period
`ifndef PROT_CTRL_MAP_VH
`define PROT_CTRL_MAP_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_OUT_ENABLE 12'h000
`define REG_RETRY_SELECT 12'h004
`define REG_RETRY_FREQ 12'h008
`define REG_SENSE_CTRL 12'h00C
`define REG_MIRROR_CTRL 12'h010
`define REG_STATUS 12'h014
`define REG_DIAG_STATUS 12'h018
// ----------------------------------------
// Mirror control fields
// ----------------------------------------
`define MC_CODE_LSB 0
`define MC_ENABLE 6
`define MC_FULL_SCALE 7
`define MC_DISCHARGE 8
`define MC_PULSED 9
`define MC_DSW_RETRY 10
`define MC_BULB_MODE 11
// ----------------------------------------
// Status fields
// ----------------------------------------
`define ST_ABOVE 0
`define ST_BELOW 1
`define ST_TSD 2
`define ST_TW 3
`define ST_SUPPLY 4
`define ST_DSW_ON 5
`define ST_OOR 6
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 4
`define BLANK_TIME_NS 65000
`define BLANK_CYCLES (`BLANK_TIME_NS / `CLK_PERIOD_NS)
`define LOOP_LOSS_TIME_NS 3000000
`define LOOP_LOSS_CYCLES (`LOOP_LOSS_TIME_NS / `CLK_PERIOD_NS)
`define DISCHARGE_TIME_NS 300000000
`define DISCHARGE_CYCLES (`DISCHARGE_TIME_NS / `CLK_PERIOD_NS)
`define FILTER_CYCLES 16
`define BULB_RETRY_CYCLES 32768
`define RETRY_PERIOD_RESET 16'h1000
`endif

// File: load_protection_ec_mirror_ctrl.v
// Purpose: overcurrent retry, sense mux, mirror sequencer, diag filter
// Assumes: single clock pclk, APB slave for software access
// Notes: analog comparators arrive as raw pins, three-stage synced
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "prot_ctrl_map.vh"
module load_protection_ec_mirror_ctrl #(
    parameter N_OUT = 8,
    parameter COMPANION = 6,
    parameter BULB = 4,
    parameter DSW = 7,
    parameter BLANK_CYC = `BLANK_CYCLES,
    parameter LOSS_CYC = `LOOP_LOSS_CYCLES,
    parameter DISC_CYC = `DISCHARGE_CYCLES,
    parameter BULB_RETRY_CYC = `BULB_RETRY_CYCLES
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Fault pins per output, plus shared supply and thermal pins
    input wire [N_OUT-1:0] overcurrent_raw,
    input wire [N_OUT-1:0] underload_raw,
    input wire supply_fault_raw,
    input wire thermal_warning_raw,
    input wire thermal_shutdown_raw,
    // Mirror comparators
    input wire gate_below_feedback_raw,
    input wire gate_below_400mv_raw,
    input wire fb_above_target_raw,
    input wire fb_below_target_raw,
    // External modulation per output
    input wire [N_OUT-1:0] pwm_in,
    // Outputs
    output reg [N_OUT-1:0] driver_on_ff,
    output reg all_outputs_hiz_ff,
    output reg [5:0] mirror_target_code_ff,
    output reg mirror_full_scale_ff,
    output reg mirror_gate_hold_low_ff,
    output reg discharge_switch_on_ff,
    output reg [3:0] sense_mux_select_ff,
    output reg sense_blank_ff,
    output reg sense_track_ff,
    output reg sense_sample_clear_ff
);
// ----------------------------------------
// Helpers
// ----------------------------------------
function [31:0] zext8;
    input [7:0] v;
    begin
        zext8 = {24'h000000, v};
    end
endfunction
// ----------------------------------------
// Input synchronisers
// ----------------------------------------
localparam NS = 2 * N_OUT + 7;
wire [NS-1:0] raw_in = {overcurrent_raw, underload_raw, supply_fault_raw,
    thermal_warning_raw, thermal_shutdown_raw, gate_below_feedback_raw,
    gate_below_400mv_raw, fb_above_target_raw, fb_below_target_raw};
reg [NS-1:0] s1_ff, s2_ff, s3_ff, sv_ff;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        s1_ff <= {NS{1'b0}};
        s2_ff <= {NS{1'b0}};
        s3_ff <= {NS{1'b0}};
        sv_ff <= {NS{1'b0}};
    end else begin
        s1_ff <= raw_in;
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        sv_ff <= (s2_ff & s3_ff) | (sv_ff & (s2_ff | s3_ff));
    end
end
wire [N_OUT-1:0] oc_s = sv_ff[NS-1 -: N_OUT];
wire [N_OUT-1:0] ul_s = sv_ff[N_OUT+6 : 7];
wire sup_s = sv_ff[6];
wire tw_s = sv_ff[5];
wire tsd_s = sv_ff[4];
wire gbf_s = sv_ff[3];
wire g400_s = sv_ff[2];
wire above_s = sv_ff[1];
wire below_s = sv_ff[0];
// ----------------------------------------
// APB registers
// ----------------------------------------
reg [N_OUT-1:0] out_enable_ff;
reg [N_OUT-1:0] retry_select_ff;
reg [15:0] retry_period_ff;
reg [3:0] sense_channel_select_ff;
reg [11:0] mirror_ctrl_ff;
reg [N_OUT-1:0] oc_flag_ff;
reg [N_OUT-1:0] ul_flag_ff;
reg tw_flag_ff, tsd_flag_ff, sup_flag_ff;
reg above_lat_ff, below_lat_ff;
wire loop_oor;
wire wr = psel & penable & pwrite;
wire rd = psel & penable & ~pwrite;
wire rd_diag = rd && paddr == `REG_DIAG_STATUS;
wire rd_stat = rd && paddr == `REG_STATUS;
assign pready = 1'b1;
assign pslverr = 1'b0;
always @* begin
    case (paddr)
        `REG_OUT_ENABLE: prdata = zext8(out_enable_ff);
        `REG_RETRY_SELECT: prdata = zext8(retry_select_ff);
        `REG_RETRY_FREQ: prdata = {16'h0000, retry_period_ff};
        `REG_SENSE_CTRL: prdata = {28'h0000000, sense_channel_select_ff};
        `REG_MIRROR_CTRL: prdata = {20'h00000, mirror_ctrl_ff};
        `REG_STATUS: prdata = {25'h0000000, loop_oor, discharge_switch_on_ff,
            sup_flag_ff, tw_flag_ff, tsd_flag_ff, below_lat_ff, above_lat_ff};
        `REG_DIAG_STATUS: prdata = {16'h0000, ul_flag_ff, oc_flag_ff};
        default: prdata = 32'h00000000;
    endcase
end
wire mirror_regulator_enable = mirror_ctrl_ff[`MC_ENABLE];
wire discharge_switch_enable = mirror_ctrl_ff[`MC_DISCHARGE];
wire pulsed_discharge_enable = mirror_ctrl_ff[`MC_PULSED] & discharge_switch_enable;
wire [5:0] target_code = mirror_ctrl_ff[5:0];
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        out_enable_ff <= {N_OUT{1'b0}};
        retry_select_ff <= {N_OUT{1'b0}};
        retry_period_ff <= `RETRY_PERIOD_RESET;
        sense_channel_select_ff <= 4'h0;
        mirror_ctrl_ff <= 12'h000;
    end else if (wr) begin
        case (paddr)
            `REG_OUT_ENABLE: out_enable_ff <= pwdata[N_OUT-1:0];
            `REG_RETRY_SELECT: retry_select_ff <= pwdata[N_OUT-1:0];
            `REG_RETRY_FREQ: retry_period_ff <= pwdata[15:0];
            `REG_SENSE_CTRL: sense_channel_select_ff <= pwdata[3:0];
            `REG_MIRROR_CTRL: mirror_ctrl_ff <= pwdata[11:0];
            default: ;
        endcase
    end
end
// ----------------------------------------
// Diagnostic filters and flags
// ----------------------------------------
localparam NF = 2 * N_OUT + 3;
// Overcurrent only counts while the driver conducts, so a retry can re-qualify it
wire [N_OUT-1:0] oc_live = oc_s & driver_on_ff;
wire [NF-1:0] fault_s = {oc_live, ul_s, sup_s, tw_s, tsd_s};
wire [NF-1:0] fault_q;
genvar g;
generate
    for (g = 0; g < NF; g = g + 1) begin : filt
        reg [4:0] cnt_ff;
        always @(posedge pclk or negedge presetn) begin
            if (!presetn)
                cnt_ff <= 5'h00;
            else if (!fault_s[g])
                cnt_ff <= 5'h00;
            else if (cnt_ff != `FILTER_CYCLES)
                cnt_ff <= cnt_ff + 5'h01;
        end
        assign fault_q[g] = (cnt_ff == `FILTER_CYCLES);
    end
endgenerate
wire [N_OUT-1:0] oc_q = fault_q[NF-1 -: N_OUT];
wire [N_OUT-1:0] ul_q = fault_q[N_OUT+2 : 3];
// Retry timers per output
wire [N_OUT-1:0] retry_done;
wire [N_OUT-1:0] retry_ok;
generate
    for (g = 0; g < N_OUT; g = g + 1) begin : rtry
        reg [15:0] rc_ff;
        wire [15:0] lim = (g == BULB && mirror_ctrl_ff[`MC_BULB_MODE]) ?
            BULB_RETRY_CYC[15:0] : retry_period_ff;
        always @(posedge pclk or negedge presetn) begin
            if (!presetn)
                rc_ff <= 16'h0000;
            else if (!oc_flag_ff[g])
                rc_ff <= 16'h0000;
            else if (rc_ff != lim)
                rc_ff <= rc_ff + 16'h0001;
        end
        assign retry_ok[g] = retry_select_ff[g] &
            ~(g == DSW && pulsed_discharge_enable);
        assign retry_done[g] = retry_ok[g] && oc_flag_ff[g] && rc_ff == lim;
    end
endgenerate
// Retry off leaves flag latched until a REG_DIAG_STATUS read, so channel stays off until then
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        oc_flag_ff <= {N_OUT{1'b0}};
        ul_flag_ff <= {N_OUT{1'b0}};
        tw_flag_ff <= 1'b0;
        tsd_flag_ff <= 1'b0;
        sup_flag_ff <= 1'b0;
    end else begin
        oc_flag_ff <= (oc_flag_ff & ~retry_done & ~(rd_diag ? {N_OUT{1'b1}} :
            {N_OUT{1'b0}})) | oc_q;
        ul_flag_ff <= (ul_flag_ff & ~(rd_diag ? {N_OUT{1'b1}} : {N_OUT{1'b0}})) | ul_q;
        tw_flag_ff <= (tw_flag_ff & ~rd_stat) | fault_q[1];
        tsd_flag_ff <= (tsd_flag_ff & ~rd_stat) | fault_q[0];
        sup_flag_ff <= (sup_flag_ff & ~rd_stat) | fault_q[2];
    end
end
// ----------------------------------------
// Driver outputs
// ----------------------------------------
wire [N_OUT-1:0] comp_mask = {{(N_OUT-1){1'b0}}, 1'b1} << COMPANION;
wire [N_OUT-1:0] pwm_eff = mirror_regulator_enable ? (pwm_in | comp_mask) : pwm_in;
wire [N_OUT-1:0] en_eff = mirror_regulator_enable ? (out_enable_ff | comp_mask) :
    out_enable_ff;
// Underload and warning flags are not in this path
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        driver_on_ff <= {N_OUT{1'b0}};
        all_outputs_hiz_ff <= 1'b1;
    end else begin
        all_outputs_hiz_ff <= tsd_flag_ff;
        driver_on_ff <= tsd_flag_ff ? {N_OUT{1'b0}} :
            (en_eff & pwm_eff & ~oc_flag_ff);
    end
end
// ----------------------------------------
// Current sense
// ----------------------------------------
wire sel_on = driver_on_ff[sense_channel_select_ff[2:0]] &
    ~sense_channel_select_ff[3];
reg sel_on_d_ff;
reg [3:0] sel_d_ff;
reg [15:0] blank_cnt_ff;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sel_on_d_ff <= 1'b0;
        sel_d_ff <= 4'h0;
        blank_cnt_ff <= 16'h0000;
        sense_mux_select_ff <= 4'h0;
        sense_blank_ff <= 1'b0;
        sense_track_ff <= 1'b0;
        sense_sample_clear_ff <= 1'b0;
    end else begin
        sel_on_d_ff <= sel_on;
        sel_d_ff <= sense_channel_select_ff;
        sense_mux_select_ff <= sense_channel_select_ff;
        if (sel_on && (!sel_on_d_ff || sel_d_ff != sense_channel_select_ff))
            blank_cnt_ff <= BLANK_CYC[15:0];
        else if (blank_cnt_ff != 16'h0000)
            blank_cnt_ff <= blank_cnt_ff - 16'h0001;
        sense_blank_ff <= blank_cnt_ff != 16'h0000;
        sense_track_ff <= sel_on;
        sense_sample_clear_ff <= (sel_d_ff != sense_channel_select_ff) & ~sel_on;
    end
end
// ----------------------------------------
// Mirror sequencer
// ----------------------------------------
localparam ST_IDLE = 2'b00;
localparam ST_REG = 2'b01;
localparam ST_DISC = 2'b10;
reg [1:0] st_ff;
reg [26:0] tmr_ff;
assign loop_oor = (st_ff == ST_REG) & (gbf_s | g400_s);
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        st_ff <= ST_IDLE;
        tmr_ff <= 27'h0000000;
        above_lat_ff <= 1'b0;
        below_lat_ff <= 1'b0;
        mirror_target_code_ff <= 6'h00;
        mirror_full_scale_ff <= 1'b0;
        mirror_gate_hold_low_ff <= 1'b1;
        discharge_switch_on_ff <= 1'b0;
    end else begin
        mirror_full_scale_ff <= mirror_ctrl_ff[`MC_FULL_SCALE];
        case (st_ff)
            ST_IDLE: begin
                tmr_ff <= 27'h0000000;
                mirror_target_code_ff <= 6'h00;
                mirror_gate_hold_low_ff <= 1'b1;
                discharge_switch_on_ff <= discharge_switch_enable && target_code == 6'h00;
                if (mirror_regulator_enable)
                    st_ff <= ST_REG;
            end
            ST_REG: begin
                mirror_target_code_ff <= target_code;
                mirror_gate_hold_low_ff <= 1'b0;
                discharge_switch_on_ff <= discharge_switch_enable &&
                    target_code == 6'h00;
                above_lat_ff <= above_s;
                below_lat_ff <= below_s;
                if (!loop_oor || !pulsed_discharge_enable)
                    tmr_ff <= 27'h0000000;
                else
                    tmr_ff <= tmr_ff + 27'h0000001;
                if (!mirror_regulator_enable) begin
                    st_ff <= ST_IDLE;
                end else if (pulsed_discharge_enable && tmr_ff >= LOSS_CYC[26:0]) begin
                    st_ff <= ST_DISC;
                    tmr_ff <= 27'h0000000;
                    above_lat_ff <= above_s;
                    below_lat_ff <= below_s;
                end
            end
            ST_DISC: begin
                mirror_target_code_ff <= 6'h00;
                mirror_gate_hold_low_ff <= 1'b1;
                discharge_switch_on_ff <= 1'b1;
                tmr_ff <= tmr_ff + 27'h0000001;
                if (!mirror_regulator_enable || !pulsed_discharge_enable) begin
                    st_ff <= ST_IDLE;
                end else if (tmr_ff >= DISC_CYC[26:0]) begin
                    st_ff <= ST_REG;
                    tmr_ff <= 27'h0000000;
                    discharge_switch_on_ff <= 1'b0;
                    above_lat_ff <= above_s;
                end
            end
            default: st_ff <= ST_IDLE;
        endcase
    end
end
endmodule

// File: prot_ctrl_sva.sv
// Purpose: output checks for the protection block
// Assumes: one clock, async active-low reset
// Notes: oc check watches output 1, which is never set to retry
`timescale 1ns/1ps
module prot_ctrl_sva #(
    parameter N_OUT = 8,
    parameter COMPANION = 6,
    parameter BLANK_CYC = 20,
    parameter DISC_CYC = 100
) (
    // Clock, reset, inputs
    input wire logic pclk,
    input wire logic presetn,
    input wire logic thermal_shutdown_raw,
    input wire logic [N_OUT-1:0] overcurrent_raw,
    // Outputs
    input wire logic [N_OUT-1:0] driver_on_ff,
    input wire logic all_outputs_hiz_ff,
    input wire logic [5:0] mirror_target_code_ff,
    input wire logic mirror_gate_hold_low_ff,
    input wire logic discharge_switch_on_ff,
    input wire logic sense_blank_ff,
    input wire logic sense_track_ff,
    input wire logic sense_sample_clear_ff
);
    // ----------------
    // Run-length counters
    // ----------------
    int blank_cnt_ff;
    int pulse_cnt_ff;
    int oc_cnt_ff;
    wire pulse = discharge_switch_on_ff && mirror_gate_hold_low_ff;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blank_cnt_ff <= 0;
            pulse_cnt_ff <= 0;
            oc_cnt_ff <= 0;
        end else begin
            blank_cnt_ff <= sense_blank_ff ? blank_cnt_ff + 1 : 0;
            pulse_cnt_ff <= pulse ? pulse_cnt_ff + 1 : 0;
            oc_cnt_ff <= overcurrent_raw[1] ? oc_cnt_ff + 1 : 0;
        end
    end
    // ----------------
    // Properties
    // ----------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_pulse; pulse [*8]; endsequence
    property p_hiz_off; all_outputs_hiz_ff |-> driver_on_ff == '0; endproperty
    a_hiz_off: assert property (p_hiz_off) else $error("drive in shutdown");
    property p_tsd_filt; $rose(all_outputs_hiz_ff) |-> $past(thermal_shutdown_raw, 16); endproperty
    a_tsd_filt: assert property (p_tsd_filt) else $error("shutdown unfiltered");
    property p_oc_off; oc_cnt_ff >= 30 |-> !driver_on_ff[1]; endproperty
    a_oc_off: assert property (p_oc_off) else $error("overcurrent ignored");
    property p_blank_max; blank_cnt_ff <= BLANK_CYC; endproperty
    a_blank_max: assert property (p_blank_max) else $error("blanking too long");
    // A discharge pulse starts out of regulation, where the gate was driven
    property p_pulse_min; $rose(pulse) && !$past(mirror_gate_hold_low_ff) |-> s_pulse;
    endproperty
    a_pulse_min: assert property (p_pulse_min) else $error("pulse cut short");
    property p_pulse_max; pulse_cnt_ff <= DISC_CYC; endproperty
    a_pulse_max: assert property (p_pulse_max) else $error("pulse too long");
    property p_dsw_code; discharge_switch_on_ff |-> mirror_target_code_ff == 6'h00; endproperty
    a_dsw_code: assert property (p_dsw_code) else $error("switch on, code set");
    property p_comp_on; $fell(mirror_gate_hold_low_ff) |-> ##[0:2] driver_on_ff[COMPANION];
    endproperty
    a_comp_on: assert property (p_comp_on) else $error("companion off");
    property p_clr_trk; sense_sample_clear_ff |-> !sense_track_ff; endproperty
    a_clr_trk: assert property (p_clr_trk) else $error("tracks while cleared");
endmodule
bind load_protection_ec_mirror_ctrl prot_ctrl_sva #(.N_OUT(N_OUT), .COMPANION(COMPANION),
    .BLANK_CYC(BLANK_CYC), .DISC_CYC(DISC_CYC)) u_prot_ctrl_sva (.pclk, .presetn,
    .thermal_shutdown_raw, .overcurrent_raw, .driver_on_ff, .all_outputs_hiz_ff,
    .mirror_target_code_ff, .mirror_gate_hold_low_ff, .discharge_switch_on_ff,
    .sense_blank_ff, .sense_track_ff, .sense_sample_clear_ff);

// File: host_apb_model.sv
// Purpose: APB host standing in for the controlling microcontroller
// Assumes: called right after a rising edge
// Notes: holds each request until pready is sampled high
`timescale 1ns/1ps
module host_apb_model (
    // Clock
    input wire logic pclk,
    // APB
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] rq);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rq = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
        @(posedge pclk);
    endtask
endmodule

// File: load_protection_ec_mirror_ctrl_tb.sv
// Purpose: self-checking bench for the protection block
// Assumes: host model drives the registers
// Notes: long counts shortened by parameters
`timescale 1ns/1ps
`include "prot_ctrl_map.vh"
module load_protection_ec_mirror_ctrl_tb;
    localparam int BLANK = 20;
    localparam int LOSS = 50;
    localparam int DISC = 100;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, hiz, fs, ghl, dsw, blank, track, clr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0] oc = 8'h00, ul = 8'h00, pwm = 8'h00, drv, en;
    logic tw = 1'b0, tsd = 1'b0, sf = 1'b0, gbf = 1'b0, g4 = 1'b0, fa = 1'b0, fb = 1'b0;
    logic [5:0] code;
    logic [3:0] msel;
    int mismatches = 0, n_compared = 0, cycles = 0, seed, i, c0, c4;
    always #2 pclk = ~pclk;
    host_apb_model u_host_apb_model (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready);
    load_protection_ec_mirror_ctrl #(.BLANK_CYC(BLANK), .LOSS_CYC(LOSS), .DISC_CYC(DISC),
        .BULB_RETRY_CYC(30)) u_load_protection_ec_mirror_ctrl (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .overcurrent_raw(oc), .underload_raw(ul), .supply_fault_raw(sf),
        .thermal_warning_raw(tw), .thermal_shutdown_raw(tsd), .gate_below_feedback_raw(gbf),
        .gate_below_400mv_raw(g4), .fb_above_target_raw(fa), .fb_below_target_raw(fb),
        .pwm_in(pwm), .driver_on_ff(drv), .all_outputs_hiz_ff(hiz),
        .mirror_target_code_ff(code), .mirror_full_scale_ff(fs), .mirror_gate_hold_low_ff(ghl),
        .discharge_switch_on_ff(dsw), .sense_mux_select_ff(msel), .sense_blank_ff(blank),
        .sense_track_ff(track), .sense_sample_clear_ff(clr));
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_host_apb_model.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [11:0] a);
        u_host_apb_model.xfer(1'b0, a, 32'h0, q);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic on_cnt(input int ch, input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge pclk);
            c += drv[ch];
        end
    endtask
    function automatic logic [7:0] exp_drv(input logic [7:0] e, input logic [7:0] p);
        return e & p;
    endfunction
    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 8000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        seed = 72;
        wt(16);
        presetn <= 1'b1;
        wt(2);
        chk({hiz, drv}, 9'h000);
        rd(`REG_RETRY_FREQ);
        chk(q, 32'h0000_1000);
        wr(12'hFFC, 32'hFFFF_FFFF);
        rd(12'hFFC);
        chk(q, 32'h0);
        chk({pslverr, pready}, 2'b01);
        wr(`REG_OUT_ENABLE, 32'hFF);
        pwm <= 8'hFF;
        oc <= 8'h02;
        wt(10);
        oc <= 8'h00;
        wt(20);
        chk(drv, 8'hFF);
        oc <= 8'h02;
        wt(40);
        chk(drv, 8'hFD);
        oc <= 8'h00;
        wt(40);
        chk(drv, 8'hFD);
        rd(`REG_DIAG_STATUS);
        chk(q[7:0], 8'h02);
        wt(3);
        chk(drv, 8'hFF);
        $display("test latch done");
        wr(`REG_RETRY_FREQ, 32'h3E8);
        wr(`REG_MIRROR_CTRL, 32'h800);
        wr(`REG_RETRY_SELECT, 32'h11);
        oc <= 8'h11;
        wt(40);
        on_cnt(4, 300, c4);
        on_cnt(0, 300, c0);
        chk({c4 > 0, c0 > 0}, 2'b10);
        oc <= 8'h00;
        wr(`REG_MIRROR_CTRL, 32'h0);
        wr(`REG_RETRY_FREQ, 32'h28);
        rd(`REG_DIAG_STATUS);
        oc <= 8'h11;
        wt(40);
        on_cnt(0, 300, c0);
        on_cnt(4, 100, c4);
        chk({c0 > 0, c4 > 0}, 2'b11);
        wr(`REG_RETRY_SELECT, 32'h0);
        wt(100);
        on_cnt(0, 200, c0);
        chk(c0, 0);
        oc <= 8'h00;
        wt(8);
        rd(`REG_DIAG_STATUS);
        $display("test retry done");
        for (i = 0; i < 20; i++) begin
            en = 8'($random(seed));
            wr(`REG_OUT_ENABLE, {24'h0, en});
            pwm <= 8'($random(seed));
            ul <= 8'($random(seed));
            tw <= 1'($random(seed));
            fb <= 1'($random(seed));
            wt(30);
            chk(drv, exp_drv(en, pwm));
        end
        ul <= 8'h00;
        wr(`REG_OUT_ENABLE, 32'hFF);
        pwm <= 8'h00;
        $display("test random done");
        for (i = 0; i < 16; i++) begin
            wr(`REG_SENSE_CTRL, i);
            wt(1);
            chk(msel, i);
        end
        wr(`REG_SENSE_CTRL, 32'h5);
        wt(1);
        chk({msel, clr}, 5'h0B);
        pwm <= 8'h20;
        wt(4);
        chk(blank, 1'b1);
        wt(BLANK + 4);
        chk({blank, track, clr}, 3'b010);
        pwm <= 8'h00;
        wt(4);
        chk({track, clr}, 2'b00);
        $display("test sense done");
        wr(`REG_OUT_ENABLE, 32'h0);
        wr(`REG_MIRROR_CTRL, 32'hEA);
        wt(3);
        chk({ghl, fs, code, drv[6]}, 9'h0D5);
        wr(`REG_MIRROR_CTRL, 32'h6A);
        wt(3);
        chk({fs, drv[6]}, 2'b01);
        wr(`REG_MIRROR_CTRL, 32'h2A);
        wt(3);
        chk({ghl, drv[6]}, 2'b10);
        wr(`REG_MIRROR_CTRL, 32'h140);
        wt(10);
        chk(dsw, 1'b1);
        wr(`REG_MIRROR_CTRL, 32'h0);
        fa <= 1'b1;
        wr(`REG_MIRROR_CTRL, 32'h350);
        for (i = 0; i < 2; i++) begin
            if (i == 0)
                gbf <= 1'b1;
            else
                g4 <= 1'b1;
            wt(LOSS + 15);
            rd(`REG_STATUS);
            chk({dsw, ghl, code, q[5], q[0]}, 10'h303);
            gbf <= 1'b0;
            g4 <= 1'b0;
            wt(DISC);
            chk({dsw, ghl, code}, 8'h10);
        end
        wr(`REG_MIRROR_CTRL, 32'h0);
        $display("test mirror done");
        wr(`REG_OUT_ENABLE, 32'hFF);
        pwm <= 8'hFF;
        tw <= 1'b1;
        wt(30);
        chk(drv, 8'hFF);
        tsd <= 1'b1;
        wt(30);
        chk({hiz, drv}, 9'h100);
        tsd <= 1'b0;
        wt(30);
        chk(hiz, 1'b1);
        rd(`REG_STATUS);
        chk(q[3:2], 2'b11);
        wt(3);
        chk({hiz, drv}, 9'h0FF);
        $display("test thermal done");
        summarize();
    end
endmodule
